// [reset_strap_latch.sv]
// Functional notes
// [R1] strap pin levels are sampled while reset is held and set the config
// [R2] after reset the pins resume rx data and led roles, config unchanged
// [R3] four address straps become station address bits 4 to 1
// [R4] port a address has bit 0 clear, even values 0 to 30
// [R5] port b address has bit 0 set, odd values 1 to 31
// [R6] unconnected address straps read 0 through internal pull-downs
// [R7] negotiation strap high: negotiate, advertising the capability straps
// [R8] negotiation strap low: fixed speed and duplex from capability straps
// [R9] latched negotiation and capability straps load control defaults
// [R10] unconnected negotiation straps read 111 through internal pull-ups
// [R11] board overrides with about 2.2 kohm, never tied to a rail
// [R12] every reset assertion re-samples all straps
// [R13] forced 00 10 half, 01 10 full, 10 100 half, 11 100 full
`timescale 1ns/1ps
`default_nettype none
`include "strap_latch_consts.svh"

module reset_strap_latch
  import strap_latch_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire strap_pins_type pad_in,
  output strap_pins_type pad_out,
  output strap_pins_type pad_oe,
  output strap_pins_type pad_pull_up,
  input wire port_func_type func_a,
  input wire port_func_type func_b,
  output port_cfg_type port_a_cfg,
  output port_cfg_type port_b_cfg,
  output logic strap_ready,
  output logic short_reset
);

  typedef struct packed {
    strap_pins_type sync1;
    strap_pins_type sync2;
    strap_set_type strap;
    phase_type phase;
    logic [`HOLD_COUNT_W-1:0] hold_count;
    logic short_reset;
    logic ready;
    port_cfg_type cfg_a;
    port_cfg_type cfg_b;
    strap_pins_type pad_out;
    strap_pins_type pad_oe;
  } latch_state_type;

  localparam logic [`HOLD_COUNT_W-1:0] HOLD_MIN =
    `HOLD_COUNT_W'(`RESET_MIN_CYC);

  latch_state_type state;
  latch_state_type next_state;
  port_cfg_type dec_a;
  port_cfg_type dec_b;

  // pin order to strap meaning
  function automatic strap_set_type to_straps(input strap_pins_type p);
    strap_set_type s;
    s.station_addr_strap_bit1 = p.rxd0_a;
    s.station_addr_strap_bit2 = p.rxd1_a;
    s.station_addr_strap_bit3 = p.rxd0_b;
    s.station_addr_strap_bit4 = p.rxd1_b;
    s.negotiation_enable_strap_a = p.led_act_a;
    s.capability_strap_bit1_a = p.led_speed_a;
    s.capability_strap_bit0_a = p.led_link_a;
    s.negotiation_enable_strap_b = p.led_act_b;
    s.capability_strap_bit1_b = p.led_speed_b;
    s.capability_strap_bit0_b = p.led_link_b;
    return s;
  endfunction

  // led pins idle at their strap level so the board pull stays valid;
  // an active led drives against it
  function automatic strap_pins_type func_pins(input strap_set_type s,
      input port_func_type fa, input port_func_type fb);
    strap_pins_type p;
    p.rxd0_a = fa.rx_data[0];
    p.rxd1_a = fa.rx_data[1];
    p.rxd0_b = fb.rx_data[0];
    p.rxd1_b = fb.rx_data[1];
    p.led_act_a = fa.act_led ^ s.negotiation_enable_strap_a;
    p.led_speed_a = fa.speed_led ^ s.capability_strap_bit1_a;
    p.led_link_a = fa.link_led ^ s.capability_strap_bit0_a;
    p.led_act_b = fb.act_led ^ s.negotiation_enable_strap_b;
    p.led_speed_b = fb.speed_led ^ s.capability_strap_bit1_b;
    p.led_link_b = fb.link_led ^ s.capability_strap_bit0_b;
    return p;
  endfunction

  strap_mode_decoder u_dec_a (
    .addr_hi({state.strap.station_addr_strap_bit4,
              state.strap.station_addr_strap_bit3,
              state.strap.station_addr_strap_bit2,
              state.strap.station_addr_strap_bit1}),
    .addr_lsb(`PORT_A_ADDR_LSB), // R4
    .neg_en(state.strap.negotiation_enable_strap_a),
    .cap({state.strap.capability_strap_bit1_a,
          state.strap.capability_strap_bit0_a}),
    .cfg(dec_a)
  );

  strap_mode_decoder u_dec_b (
    .addr_hi({state.strap.station_addr_strap_bit4,
              state.strap.station_addr_strap_bit3,
              state.strap.station_addr_strap_bit2,
              state.strap.station_addr_strap_bit1}),
    .addr_lsb(`PORT_B_ADDR_LSB), // R5
    .neg_en(state.strap.negotiation_enable_strap_b),
    .cap({state.strap.capability_strap_bit1_b,
          state.strap.capability_strap_bit0_b}),
    .cfg(dec_b)
  );

  always_comb begin
    next_state = state;
    // synchronisers run in and out of reset
    next_state.sync1 = pad_in;
    next_state.sync2 = state.sync1;
    next_state.cfg_a = dec_a; // R9
    next_state.cfg_b = dec_b; // R9
    if (!rst_n) begin
      // pins undriven, so the pulls or board resistors set the level
      next_state.strap = to_straps(state.sync2); // R1 R12
      next_state.phase = PH_SAMPLE; // R12
      next_state.ready = 1'h0;
      next_state.short_reset = 1'h0;
      next_state.pad_oe = `PAD_OE_RESET; // R6 R10
      next_state.pad_out = `PAD_OUT_RESET;
      case (state.phase)
        PH_SAMPLE: begin
          if (state.hold_count != {`HOLD_COUNT_W{1'b1}}) begin
            next_state.hold_count = state.hold_count + 1'h1;
          end
        end
        default: begin
          // first held edge; also clears an unknown count after power-up
          next_state.hold_count = `HOLD_COUNT_FIRST;
        end
      endcase
    end else begin
      case (state.phase)
        PH_SAMPLE: begin
          // too short a hold may leave a stale synchroniser sample
          next_state.short_reset = (state.hold_count < HOLD_MIN);
          next_state.hold_count = `HOLD_COUNT_RESET;
          next_state.phase = PH_TURN;
        end
        PH_TURN: begin
          next_state.phase = PH_RUN;
          next_state.ready = 1'h1;
          next_state.pad_oe = '1; // R2
          next_state.pad_out = func_pins(state.strap, func_a, func_b); // R2
        end
        PH_RUN: begin
          next_state.pad_oe = '1; // R2
          next_state.pad_out = func_pins(state.strap, func_a, func_b); // R2
        end
        default: begin
          next_state.phase = PH_SAMPLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign pad_out = state.pad_out;
  assign pad_oe = state.pad_oe;
  assign pad_pull_up = `STRAP_PULL_UP; // R6 R10
  assign port_a_cfg = state.cfg_a;
  assign port_b_cfg = state.cfg_b;
  assign strap_ready = state.ready;
  assign short_reset = state.short_reset;

  property p_sample_at_release;
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> state.strap == to_straps($past(state.sync2));
  endproperty
  a_sample_at_release: assert property (p_sample_at_release) // R1
    else $error("strap set differs from last sample taken in reset");

  property p_release_sequence;
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> (pad_oe == '0 && !strap_ready) ##1
      (pad_oe == '0 && !strap_ready) ##1
      (pad_oe == '1 && strap_ready);
  endproperty
  a_release_sequence: assert property (p_release_sequence) // R12
    else $error("pins or ready wrong in the cycles after reset release");

  property p_latch_stable;
    @(posedge clk) disable iff (!rst_n)
    strap_ready |=> $stable(state.strap) && $stable(port_a_cfg)
      && $stable(port_b_cfg);
  endproperty
  a_latch_stable: assert property (p_latch_stable) // R2
    else $error("latched configuration changed outside reset");

  property p_led_polarity;
    @(posedge clk) disable iff (!rst_n)
    strap_ready ##1 strap_ready |-> pad_out.led_link_a ==
      ($past(func_a.link_led) ^ state.strap.capability_strap_bit0_a)
      && pad_out.rxd0_b == $past(func_b.rx_data[0]);
  endproperty
  a_led_polarity: assert property (p_led_polarity) // R2
    else $error("functional pin output wrong after reset");

  property p_addr_port_a;
    @(posedge clk) disable iff (!rst_n)
    strap_ready |-> port_a_cfg.addr == {state.strap.station_addr_strap_bit4,
      state.strap.station_addr_strap_bit3,
      state.strap.station_addr_strap_bit2,
      state.strap.station_addr_strap_bit1, 1'h0};
  endproperty
  a_addr_port_a: assert property (p_addr_port_a) // R3
    else $error("port a address not strap bits with bit 0 clear");

  property p_addr_port_b;
    @(posedge clk) disable iff (!rst_n)
    strap_ready |-> port_b_cfg.addr == {port_a_cfg.addr[4:1], 1'h1}
      && !port_a_cfg.addr[0];
  endproperty
  a_addr_port_b: assert property (p_addr_port_b) // R5
    else $error("port b address not the odd partner of port a");

  property p_negotiate;
    @(posedge clk) disable iff (!rst_n)
    strap_ready && state.strap.negotiation_enable_strap_a |->
      port_a_cfg.negotiation_enable && port_a_cfg.advertise[0]
      && port_a_cfg.advertise[{state.strap.capability_strap_bit1_a,
      state.strap.capability_strap_bit0_a}];
  endproperty
  a_negotiate: assert property (p_negotiate) // R7
    else $error("negotiating port does not advertise selected mode");

  property p_forced;
    @(posedge clk) disable iff (!rst_n)
    strap_ready && !state.strap.negotiation_enable_strap_b |->
      !port_b_cfg.negotiation_enable && $onehot(port_b_cfg.advertise)
      && port_b_cfg.speed_100 == state.strap.capability_strap_bit1_b
      && port_b_cfg.full_duplex == state.strap.capability_strap_bit0_b;
  endproperty
  a_forced: assert property (p_forced) // R8
    else $error("forced port mode does not follow capability straps");

  property p_forced_table;
    @(posedge clk) disable iff (!rst_n)
    strap_ready && !port_a_cfg.negotiation_enable |->
      port_a_cfg.advertise == (4'h1 << {port_a_cfg.speed_100,
      port_a_cfg.full_duplex});
  endproperty
  a_forced_table: assert property (p_forced_table) // R13
    else $error("forced mode encoding wrong");

  property p_control_defaults;
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) ##1 1'b1 |-> ##1
      port_a_cfg.negotiation_enable == state.strap.negotiation_enable_strap_a
      && port_b_cfg.negotiation_enable ==
      state.strap.negotiation_enable_strap_b;
  endproperty
  a_control_defaults: assert property (p_control_defaults) // R9
    else $error("control defaults not loaded from latched straps");

  property p_undriven_in_reset;
    @(posedge clk)
    disable iff (rst_n)
    $fell(rst_n) |=> pad_oe == '0 && pad_pull_up == 10'h03F;
  endproperty
  a_undriven_in_reset: assert property (p_undriven_in_reset) // R6
    else $error("strap pins driven while reset is held");

  property p_short_flag_set;
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) && $past(rst_n, 10) |=> short_reset;
  endproperty
  a_short_flag_set: assert property (p_short_flag_set) // R12
    else $error("reset held under ten cycles not flagged short");

  property p_short_flag_clear;
    @(posedge clk)
    (!rst_n) [*5] ##1 (!rst_n) [*5] ##1 rst_n |=> !short_reset;
  endproperty
  a_short_flag_clear: assert property (p_short_flag_clear) // R12
    else $error("full length reset flagged short");

  property p_reset_outputs;
    @(posedge clk)
    !rst_n |=> pad_oe == '0 && pad_out == '0 && !strap_ready
      && !short_reset;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) // R1
    else $error("pins driven or flags set while reset is held");

  property p_strap_tracks_pins;
    @(posedge clk)
    (!rst_n) [*4] |=> state.strap == to_straps($past(pad_in, 3));
  endproperty
  a_strap_tracks_pins: assert property (p_strap_tracks_pins) // R12
    else $error("strap set does not follow synchronised pin levels");

endmodule

`default_nettype wire

// [reset_strap_latch_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module reset_strap_latch_tb_top;
  import strap_latch_pkg::*;
  typedef struct packed {
    port_cfg_type a;
    port_cfg_type b;
    logic sr;
  } note_type;
  logic clk;
  logic rst_n;
  strap_pins_type pad_in, pad_out, pad_oe, pad_pull_up, fitted, level;
  port_func_type func_a, func_b;
  port_cfg_type port_a_cfg, port_b_cfg;
  logic strap_ready;
  logic short_reset;
  note_type notes[$];
  note_type last_note;
  int errors;
  int samples_checked;
  bit watch;

  reset_strap_latch reset_strap_latch_i (
    .clk(clk), .rst_n(rst_n), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pull_up(pad_pull_up), .func_a(func_a),
    .func_b(func_b), .port_a_cfg(port_a_cfg), .port_b_cfg(port_b_cfg),
    .strap_ready(strap_ready), .short_reset(short_reset)
  );

  strap_board_model strap_board_model_i (
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .fitted(fitted), .level(level), .pad_in(pad_in)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic port_cfg_type want(input logic [3:0] ah,
      input logic lsb, input logic n, input logic c1, input logic c0);
    port_cfg_type w;
    w.addr = {ah, lsb};
    w.negotiation_enable = n;
    w.speed_100 = c1;
    w.full_duplex = c0;
    if (n) begin
      w.advertise = 4'hF >> (2'h3 - {c1, c0});
    end else begin
      w.advertise = 4'h1 << {c1, c0};
    end
    return w;
  endfunction

  // note the expectation, then apply the board straps under reset
  task automatic run(input strap_pins_type f, input strap_pins_type l,
                     input int hold);
    strap_pins_type e;
    note_type n;
    e = (f & l) | (~f & 10'h03F);
    n.a = want(e[9:6], 1'h0, e.led_act_a, e.led_speed_a, e.led_link_a);
    n.b = want(e[9:6], 1'h1, e.led_act_b, e.led_speed_b, e.led_link_b);
    n.sr = (hold < 10);
    notes.push_back(n);
    last_note = n;
    @(negedge clk);
    fitted = f;
    level = l;
    rst_n = 1'b0;
    repeat (hold) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  // board keeps wiggling the straps after release; config must not move
  task automatic func_check(input note_type n);
    port_func_type fa, fb;
    logic [5:0] leds;
    repeat (6) begin
      fa = port_func_type'(5'($urandom));
      fb = port_func_type'(5'($urandom));
      @(negedge clk);
      func_a = fa;
      func_b = fb;
      fitted = strap_pins_type'(10'($urandom));
      level = strap_pins_type'(10'($urandom));
      @(negedge clk);
      leds = {fa.act_led, fa.speed_led, fa.link_led,
              fb.act_led, fb.speed_led, fb.link_led};
      leds ^= {n.a.negotiation_enable, n.a.speed_100, n.a.full_duplex,
               n.b.negotiation_enable, n.b.speed_100, n.b.full_duplex};
      check("led_pins", pad_out[5:0], leds);
      check("pad_pull_up", pad_pull_up, 32'h3F);
      check("pad_oe", pad_oe, 32'h3FF);
      check("rxd_a", {pad_out.rxd1_a, pad_out.rxd0_a}, fa.rx_data);
      check("rxd_b", {pad_out.rxd1_b, pad_out.rxd0_b}, fb.rx_data);
      check("led_link_a", pad_out.led_link_a,
            fa.link_led ^ n.a.full_duplex);
      check("cfg_a_held", port_a_cfg, n.a);
      check("cfg_b_held", port_b_cfg, n.b);
    end
  endtask

  initial begin
    note_type seen;
    forever begin
      @(posedge strap_ready);
      #1;
      if (watch && notes.size() > 0) begin
        seen = notes.pop_front();
        check("port_a_cfg", port_a_cfg, seen.a);
        check("port_b_cfg", port_b_cfg, seen.b);
        check("short_reset", short_reset, seen.sr);
      end
    end
  end

  initial begin
    strap_pins_type f, l;
    rst_n = 1'b0;
    fitted = '0;
    level = '0;
    func_a = '0;
    func_b = '0;
    watch = 1'b0;
    errors = 0;
    samples_checked = 0;
    void'($urandom(32'h95F5));
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    watch = 1'b1;
    run('0, '0, 10);
    run(10'h3FF, 10'h3C0, 10);
    // every negotiation and capability code, one short reset among them
    for (int c = 0; c < 8; c++) begin
      f = strap_pins_type'(10'($urandom)) | 10'h03F;
      l = {4'($urandom), c[2:0], ~c[2:0]};
      run(f, l, (c == 3) ? 9 : 10);
    end
    func_check(last_note);
    check("notes_left", notes.size(), 0);
    summarize();
  end

  // about 170 cycles expected; generous margin before declaring a hang
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule

`default_nettype wire

// [strap_board_model.sv]
`timescale 1ns/1ps
`default_nettype none

module strap_board_model
  import strap_latch_pkg::*;
(
  input wire strap_pins_type pad_out,
  input wire strap_pins_type pad_oe,
  input wire strap_pins_type pad_pull_up,
  input wire strap_pins_type fitted,
  input wire strap_pins_type level,
  output var strap_pins_type pad_in
);
  // a fitted resistor only sets the level while the device is not driving
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (fitted[i]) begin
        pad_in[i] = level[i];
      end else begin
        pad_in[i] = pad_pull_up[i];
      end
    end
  end
endmodule

`default_nettype wire

// [strap_latch_consts.svh]
`ifndef STRAP_LATCH_CONSTS_SVH
`define STRAP_LATCH_CONSTS_SVH

// device clock period and least reset hold time
`define CLK_PERIOD_NS 100
`define RESET_MIN_NS 1000
`define RESET_MIN_CYC \
  ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_COUNT_W 4

// internal pull direction per strap pin, 1 = pull-up
`define STRAP_PULL_UP 10'h03F

// port select bit of the station address
`define PORT_A_ADDR_LSB 1'h0
`define PORT_B_ADDR_LSB 1'h1

// advertisement field positions
`define ADV_10HD 0
`define ADV_10FD 1
`define ADV_100HD 2
`define ADV_100FD 3

// reset values
`define PAD_OE_RESET 10'h000
`define PAD_OUT_RESET 10'h000
`define HOLD_COUNT_RESET 4'h0
`define HOLD_COUNT_FIRST 4'h1

`endif

// [strap_latch_pkg.sv]
package strap_latch_pkg;

  typedef enum logic [1:0] {
    PH_SAMPLE,
    PH_TURN,
    PH_RUN
  } phase_type;

  // strap-capable pins, address pins in the upper four bits
  typedef struct packed {
    logic rxd1_b;
    logic rxd0_b;
    logic rxd1_a;
    logic rxd0_a;
    logic led_act_a;
    logic led_speed_a;
    logic led_link_a;
    logic led_act_b;
    logic led_speed_b;
    logic led_link_b;
  } strap_pins_type;

  typedef struct packed {
    logic station_addr_strap_bit4;
    logic station_addr_strap_bit3;
    logic station_addr_strap_bit2;
    logic station_addr_strap_bit1;
    logic negotiation_enable_strap_a;
    logic capability_strap_bit1_a;
    logic capability_strap_bit0_a;
    logic negotiation_enable_strap_b;
    logic capability_strap_bit1_b;
    logic capability_strap_bit0_b;
  } strap_set_type;

  typedef struct packed {
    logic [4:0] addr;
    logic negotiation_enable;
    logic speed_100;
    logic full_duplex;
    logic [3:0] advertise;
  } port_cfg_type;

  typedef struct packed {
    logic [1:0] rx_data;
    logic link_led;
    logic speed_led;
    logic act_led;
  } port_func_type;

endpackage

// [strap_mode_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
`include "strap_latch_consts.svh"

module strap_mode_decoder
  import strap_latch_pkg::*;
(
  input wire logic [3:0] addr_hi,
  input wire logic addr_lsb,
  input wire logic neg_en,
  input wire logic [1:0] cap,
  output port_cfg_type cfg
);

  always_comb begin
    cfg = '0;
    cfg.addr = {addr_hi, addr_lsb}; // R3
    cfg.negotiation_enable = neg_en; // R9
    cfg.speed_100 = cap[1]; // R13
    cfg.full_duplex = cap[0]; // R13
    if (neg_en) begin
      // advertise the selected mode and every slower one
      case (cap)
        2'h0: cfg.advertise = 4'h1; // R7
        2'h1: cfg.advertise = 4'h3; // R7
        2'h2: cfg.advertise = 4'h7; // R7
        default: cfg.advertise = 4'hF; // R7
      endcase
    end else begin
      // forced: only the one fixed mode is set
      case (cap)
        2'h0: cfg.advertise[`ADV_10HD] = 1'h1; // R8
        2'h1: cfg.advertise[`ADV_10FD] = 1'h1; // R8
        2'h2: cfg.advertise[`ADV_100HD] = 1'h1; // R8
        default: cfg.advertise[`ADV_100FD] = 1'h1; // R8
      endcase
    end
  end

endmodule

`default_nettype wire
